// ---- design/iasbu_alu.sv ----
// Contract
// [RULE1] basic arithmetic: register words in, word out
// [RULE2] carry add/sub uses and sets carry bit
// [RULE3] carry add/sub flags signed overflow bit
// [RULE4] three-bit condition code held here
// [RULE5] extended multiply gives double-width unsigned product
// [RULE6] extended divide gives quotient and remainder
// [RULE7] remainder follows dividend sign, modulo divisor's
// [RULE8] shifts drop bits past word edge
// [RULE9] unsigned shifts fill with zeros
// [RULE10] signed left shift faults on lost sign
// [RULE11] signed right shift replicates sign bit
// [RULE12] dividing shift adds one for negatives; the code adds one only when a one bit of a negative operand is shifted out
// [RULE13] rotate left, bit 31 wraps to 0
// [RULE14] full set of bitwise logic functions
// [RULE15] set, clear, toggle one selected bit
// [RULE16] bit test writes 010 or 000
// [RULE17] bit alter follows condition code
// [RULE18] scan finds top one, span top zero
// [RULE19] no match: all ones, code cleared
// [RULE20] zero divisor faults, no result written
`timescale 1ns/1ps
module iasbu_alu (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_resetn,
  // request from decode
  input  wire logic                      i_valid,
  input  wire iasbu_pkg::iasbu_req_t     i_req,
  output logic                           o_ready,
  // result to register file
  output logic                           o_done,
  output iasbu_pkg::iasbu_res_t          o_res,
  output logic                           o_ovf_fault,
  output logic                           o_zdiv_fault,
  // condition code
  input  wire logic                      i_cc_wr,
  input  wire logic [2:0]                i_cc_data,
  output logic [2:0]                     o_cc
);
  localparam int unsigned W = iasbu_pkg::WORD_W;
  localparam int unsigned CNT_W = iasbu_pkg::CNT_W;

  iasbu_pkg::iasbu_state_t state_reg;
  logic [W-1:0]     a;
  logic [W-1:0]     b;
  logic [4:0]       idx;
  logic [W-1:0]     bit_mask;
  logic [W:0]       sum_c;
  logic [63:0]      prod_u;
  logic [63:0]      prod_s;
  logic [W-1:0]     shl;
  logic [W-1:0]     shl_back;
  logic [W-1:0]     sra;
  logic [63:0]      rot2;
  logic [W-1:0]     res_lo_next;
  logic [W-1:0]     res_hi_next;
  logic             wr_lo_next;
  logic             wr_hi_next;
  logic [2:0]       cc_next;
  logic             cc_we;
  logic             ovf_next;
  logic             go_div;
  logic             take;
  logic [63:0]      dvd_reg;
  logic [W-1:0]     rem_reg;
  logic [W-1:0]     dvs_reg;
  logic [W-1:0]     b_reg;
  logic [CNT_W-1:0] cnt_reg;
  iasbu_pkg::iasbu_op_t op_reg;
  logic             neg_a_reg;
  logic             neg_b_reg;
  logic             dovf_reg;
  logic [W:0]       trial;
  logic [W:0]       diff;
  logic [W-1:0]     q_s;
  logic [W-1:0]     r_s;
  logic [W-1:0]     fix_lo;
  logic [W-1:0]     fix_hi;
  logic             fix_hi_wr;
  logic             fix_ovf;
  logic [2:0]       cc_reg;
  logic             div_sgn;

  function automatic logic [W:0] top_bit(input logic [W-1:0] v);
    logic [W:0] r;
    r = {1'b0, iasbu_pkg::ALL_ONES};
    for (int i = 0; i < W; i++) begin
      if (v[i]) begin
        r = {1'b1, 27'h0, 5'(i)};
      end
    end
    return r;
  endfunction : top_bit

  assign a        = i_req.src_a;
  assign b        = i_req.src_b;
  assign idx      = b[4:0];
  assign bit_mask = 32'h1 << idx;
  assign take     = i_valid && o_ready;
  assign prod_u   = {32'h0, a} * {32'h0, b};
  assign prod_s   = 64'($signed({{32{a[W-1]}}, a}) *
                        $signed({{32{b[W-1]}}, b}));
  assign shl      = a << b;
  assign shl_back = $signed(shl) >>> b;
  assign sra      = $signed(a) >>> b;
  assign rot2     = {a, a} << idx;
  assign div_sgn  = (i_req.op == iasbu_pkg::OP_DIV_INT) ||
                    (i_req.op == iasbu_pkg::OP_REM_INT) ||
                    (i_req.op == iasbu_pkg::OP_MOD_INT);

  // one-cycle operations
  always_comb begin
    logic [W:0]   tb;
    logic [W-1:0] bb;
    tb          = '0;
    bb          = '0;
    res_lo_next = '0;
    res_hi_next = '0;
    wr_lo_next  = 1'b1;
    wr_hi_next  = 1'b0;
    cc_next     = cc_reg;
    cc_we       = 1'b0;
    ovf_next    = 1'b0;
    go_div      = 1'b0;
    sum_c       = '0;
    unique case (i_req.op)
      iasbu_pkg::OP_ADD_INT: begin
        res_lo_next = a + b; // [RULE1]
        ovf_next = (a[W-1] == b[W-1]) && (res_lo_next[W-1] != a[W-1]);
      end
      iasbu_pkg::OP_ADD_ORD: res_lo_next = a + b; // [RULE1]
      iasbu_pkg::OP_SUB_INT: begin
        res_lo_next = a - b; // [RULE1]
        ovf_next = (a[W-1] != b[W-1]) && (res_lo_next[W-1] != a[W-1]);
      end
      iasbu_pkg::OP_SUB_ORD: res_lo_next = a - b; // [RULE1]
      iasbu_pkg::OP_MUL_INT: begin
        res_lo_next = prod_s[W-1:0]; // [RULE1]
        ovf_next = (prod_s[63:31] != '0) && (prod_s[63:31] != '1);
      end
      iasbu_pkg::OP_MUL_ORD: res_lo_next = prod_u[W-1:0]; // [RULE1]
      iasbu_pkg::OP_ADD_CARRY, iasbu_pkg::OP_SUB_CARRY: begin
        bb = (i_req.op == iasbu_pkg::OP_SUB_CARRY) ? ~b : b;
        sum_c = {1'b0, a} + {1'b0, bb} +
                {32'h0, cc_reg[iasbu_pkg::CC_CARRY]}; // [RULE2]
        res_lo_next = sum_c[W-1:0];
        cc_we = 1'b1;
        cc_next = '0;
        cc_next[iasbu_pkg::CC_CARRY] = sum_c[W]; // [RULE2]
        cc_next[iasbu_pkg::CC_OVF] = (a[W-1] == bb[W-1]) &&
                                     (sum_c[W-1] != a[W-1]); // [RULE3]
      end
      iasbu_pkg::OP_MUL_EXT: begin
        res_lo_next = prod_u[W-1:0]; // [RULE5]
        res_hi_next = prod_u[63:W];
        wr_hi_next  = 1'b1;
      end
      iasbu_pkg::OP_DIV_INT, iasbu_pkg::OP_DIV_ORD,
      iasbu_pkg::OP_DIV_EXT, iasbu_pkg::OP_REM_INT,
      iasbu_pkg::OP_REM_ORD, iasbu_pkg::OP_MOD_INT: begin
        wr_lo_next = 1'b0;
        go_div     = 1'b1;
      end
      iasbu_pkg::OP_SHL_ORD: res_lo_next = shl; // [RULE8] [RULE9]
      iasbu_pkg::OP_SHR_ORD: res_lo_next = a >> b; // [RULE8] [RULE9]
      iasbu_pkg::OP_SHL_INT: begin
        res_lo_next = shl; // [RULE8]
        ovf_next = (shl_back != a); // [RULE10]
      end
      iasbu_pkg::OP_SHR_INT: res_lo_next = sra; // [RULE11]
      iasbu_pkg::OP_SHR_DIV: begin
        res_lo_next = sra + {31'h0,
                      a[W-1] && ((sra << b) != a)}; // [RULE12]
      end
      iasbu_pkg::OP_ROTATE: res_lo_next = rot2[63:W]; // [RULE13]
      iasbu_pkg::OP_AND:     res_lo_next = a & b; // [RULE14]
      iasbu_pkg::OP_NOT_AND: res_lo_next = ~a & b; // [RULE14]
      iasbu_pkg::OP_AND_NOT: res_lo_next = a & ~b; // [RULE14]
      iasbu_pkg::OP_XOR:     res_lo_next = a ^ b; // [RULE14]
      iasbu_pkg::OP_OR:      res_lo_next = a | b; // [RULE14]
      iasbu_pkg::OP_NOR:     res_lo_next = ~(a | b); // [RULE14]
      iasbu_pkg::OP_XNOR:    res_lo_next = ~(a ^ b); // [RULE14]
      iasbu_pkg::OP_NOT:     res_lo_next = ~a; // [RULE14]
      iasbu_pkg::OP_NOT_OR:  res_lo_next = ~a | b; // [RULE14]
      iasbu_pkg::OP_OR_NOT:  res_lo_next = a | ~b; // [RULE14]
      iasbu_pkg::OP_NAND:    res_lo_next = ~(a & b); // [RULE14]
      iasbu_pkg::OP_BIT_SET:  res_lo_next = a | bit_mask; // [RULE15]
      iasbu_pkg::OP_BIT_CLR:  res_lo_next = a & ~bit_mask; // [RULE15]
      iasbu_pkg::OP_BIT_FLIP: res_lo_next = a ^ bit_mask; // [RULE15]
      iasbu_pkg::OP_BIT_TEST: begin
        wr_lo_next = 1'b0;
        cc_we = 1'b1;
        cc_next = a[idx] ? iasbu_pkg::CC_TRUE
                         : iasbu_pkg::CC_FALSE; // [RULE16]
      end
      iasbu_pkg::OP_BIT_ALTER: begin
        res_lo_next = a;
        if (cc_reg == iasbu_pkg::CC_TRUE) begin
          res_lo_next = a | bit_mask; // [RULE17]
        end else if (cc_reg == iasbu_pkg::CC_FALSE) begin
          res_lo_next = a & ~bit_mask; // [RULE17]
        end
      end
      iasbu_pkg::OP_BIT_SCAN, iasbu_pkg::OP_BIT_SPAN: begin
        tb = top_bit((i_req.op == iasbu_pkg::OP_BIT_SPAN) ? ~a : a);
        res_lo_next = tb[W-1:0]; // [RULE18] [RULE19]
        cc_we = 1'b1;
        cc_next = tb[W] ? iasbu_pkg::CC_TRUE
                        : iasbu_pkg::CC_FALSE; // [RULE19]
      end
      default: wr_lo_next = 1'b0;
    endcase
  end

  // divider result fix-up
  assign q_s = (neg_a_reg ^ neg_b_reg) ? -dvd_reg[W-1:0]
                                       : dvd_reg[W-1:0];
  assign r_s = neg_a_reg ? -rem_reg : rem_reg; // [RULE7]
  always_comb begin
    fix_lo    = r_s;
    fix_hi    = '0;
    fix_hi_wr = 1'b0;
    fix_ovf   = 1'b0;
    unique case (op_reg)
      iasbu_pkg::OP_DIV_INT: begin
        fix_lo  = q_s; // [RULE1]
        fix_ovf = dovf_reg;
      end
      iasbu_pkg::OP_DIV_ORD: fix_lo = dvd_reg[W-1:0]; // [RULE1]
      iasbu_pkg::OP_DIV_EXT: begin
        fix_lo    = rem_reg; // [RULE6]
        fix_hi    = dvd_reg[W-1:0];
        fix_hi_wr = 1'b1;
      end
      iasbu_pkg::OP_MOD_INT: begin
        if ((r_s != '0) && (neg_a_reg != neg_b_reg)) begin
          fix_lo = r_s + b_reg; // [RULE7]
        end
      end
      default: fix_lo = r_s;
    endcase
  end

  assign trial = {rem_reg, dvd_reg[63]};
  assign diff  = trial - {1'b0, dvs_reg};

  // sequencing
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_reg <= iasbu_pkg::ST_IDLE;
      o_ready   <= 1'b1;
      cnt_reg   <= '0;
    end else begin
      unique case (state_reg)
        iasbu_pkg::ST_IDLE: begin
          if (take && go_div && (b != iasbu_pkg::ZERO_W)) begin
            state_reg <= iasbu_pkg::ST_DIV;
            o_ready   <= 1'b0;
            cnt_reg   <= '0;
          end
        end
        iasbu_pkg::ST_DIV: begin
          cnt_reg <= cnt_reg + 7'h1;
          if (cnt_reg == iasbu_pkg::CNT_LAST) begin
            state_reg <= iasbu_pkg::ST_FIX;
          end
        end
        iasbu_pkg::ST_FIX: begin
          state_reg <= iasbu_pkg::ST_IDLE;
          o_ready   <= 1'b1;
        end
      endcase
    end
  end

  // restoring divider datapath
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dvd_reg   <= '0;
      rem_reg   <= '0;
      dvs_reg   <= '0;
      b_reg     <= '0;
      op_reg    <= iasbu_pkg::OP_ADD_ORD;
      neg_a_reg <= 1'b0;
      neg_b_reg <= 1'b0;
      dovf_reg  <= 1'b0;
    end else if (state_reg == iasbu_pkg::ST_IDLE && take && go_div) begin
      op_reg    <= i_req.op;
      b_reg     <= b;
      rem_reg   <= '0;
      neg_a_reg <= div_sgn && a[W-1];
      neg_b_reg <= div_sgn && b[W-1];
      dovf_reg  <= (a == iasbu_pkg::WORD_MIN) && (b == iasbu_pkg::ALL_ONES);
      dvs_reg   <= (div_sgn && b[W-1]) ? -b : b;
      if (i_req.op == iasbu_pkg::OP_DIV_EXT) begin
        dvd_reg <= {i_req.src_c, a}; // [RULE6]
      end else begin
        dvd_reg <= {32'h0, (div_sgn && a[W-1]) ? -a : a};
      end
    end else if (state_reg == iasbu_pkg::ST_DIV) begin
      rem_reg <= diff[W] ? trial[W-1:0] : diff[W-1:0];
      dvd_reg <= {dvd_reg[62:0], ~diff[W]};
    end
  end

  // result and fault outputs
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_done       <= 1'b0;
      o_res        <= '0;
      o_ovf_fault  <= 1'b0;
      o_zdiv_fault <= 1'b0;
    end else begin
      o_done       <= 1'b0;
      o_ovf_fault  <= 1'b0;
      o_zdiv_fault <= 1'b0;
      o_res.wr_lo  <= 1'b0;
      o_res.wr_hi  <= 1'b0;
      if (state_reg == iasbu_pkg::ST_IDLE && take) begin
        if (!go_div) begin
          o_done      <= 1'b1;
          o_res       <= {res_lo_next, res_hi_next, wr_lo_next, wr_hi_next};
          o_ovf_fault <= ovf_next; // [RULE10]
        end else if (b == iasbu_pkg::ZERO_W) begin
          o_done       <= 1'b1;
          o_zdiv_fault <= 1'b1; // [RULE20]
        end
      end else if (state_reg == iasbu_pkg::ST_FIX) begin
        o_done      <= 1'b1;
        o_res       <= {fix_lo, fix_hi, 1'b1, fix_hi_wr};
        o_ovf_fault <= fix_ovf;
      end
    end
  end

  // condition code state
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cc_reg <= iasbu_pkg::CC_RESET;
    end else if (state_reg == iasbu_pkg::ST_IDLE && take && cc_we) begin
      cc_reg <= cc_next; // [RULE4]
    end else if (i_cc_wr) begin
      cc_reg <= i_cc_data; // [RULE4]
    end
  end

  assign o_cc = cc_reg;
endmodule : iasbu_alu

// ---- design/iasbu_pkg.sv ----
package iasbu_pkg;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned CC_W      = 3;
  localparam int unsigned IDX_W     = 5;
  localparam int unsigned DIV_STEPS = 64;
  localparam int unsigned CNT_W     = 7;
  localparam logic [CNT_W-1:0] CNT_LAST = 7'h3F;
  localparam logic [CC_W-1:0]  CC_TRUE  = 3'h2;
  localparam logic [CC_W-1:0]  CC_FALSE = 3'h0;
  localparam logic [CC_W-1:0]  CC_RESET = 3'h0;
  localparam int unsigned CC_CARRY  = 1;
  localparam int unsigned CC_OVF    = 0;
  localparam logic [WORD_W-1:0] ALL_ONES = 32'hFFFFFFFF;
  localparam logic [WORD_W-1:0] WORD_MIN = 32'h80000000;
  localparam logic [WORD_W-1:0] ZERO_W   = 32'h00000000;

  typedef enum logic [5:0] {
    OP_ADD_INT   = 6'h00, OP_ADD_ORD   = 6'h01,
    OP_SUB_INT   = 6'h02, OP_SUB_ORD   = 6'h03,
    OP_MUL_INT   = 6'h04, OP_MUL_ORD   = 6'h05,
    OP_DIV_INT   = 6'h06, OP_DIV_ORD   = 6'h07,
    OP_ADD_CARRY = 6'h08, OP_SUB_CARRY = 6'h09,
    OP_MUL_EXT   = 6'h0A, OP_DIV_EXT   = 6'h0B,
    OP_REM_INT   = 6'h0C, OP_REM_ORD   = 6'h0D,
    OP_MOD_INT   = 6'h0E,
    OP_SHL_ORD   = 6'h10, OP_SHR_ORD   = 6'h11,
    OP_SHL_INT   = 6'h12, OP_SHR_INT   = 6'h13,
    OP_SHR_DIV   = 6'h14, OP_ROTATE    = 6'h15,
    OP_AND       = 6'h18, OP_NOT_AND   = 6'h19,
    OP_AND_NOT   = 6'h1A, OP_XOR       = 6'h1B,
    OP_OR        = 6'h1C, OP_NOR       = 6'h1D,
    OP_XNOR      = 6'h1E, OP_NOT       = 6'h1F,
    OP_NOT_OR    = 6'h20, OP_OR_NOT    = 6'h21,
    OP_NAND      = 6'h22,
    OP_BIT_SET   = 6'h28, OP_BIT_CLR   = 6'h29,
    OP_BIT_FLIP  = 6'h2A, OP_BIT_TEST  = 6'h2B,
    OP_BIT_ALTER = 6'h2C, OP_BIT_SCAN  = 6'h2D,
    OP_BIT_SPAN  = 6'h2E
  } iasbu_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DIV  = 3'b010,
    ST_FIX  = 3'b100
  } iasbu_state_t;

  typedef struct packed {
    iasbu_op_t         op;
    logic [WORD_W-1:0] src_a;
    logic [WORD_W-1:0] src_b;
    logic [WORD_W-1:0] src_c;
  } iasbu_req_t;

  typedef struct packed {
    logic [WORD_W-1:0] lo;
    logic [WORD_W-1:0] hi;
    logic              wr_lo;
    logic              wr_hi;
  } iasbu_res_t;
endpackage : iasbu_pkg

// ---- verif/iasbu_asserts.sv ----
`timescale 1ns/1ps
module iasbu_asserts (
  // clock and reset
  input wire logic                  i_clk,
  input wire logic                  i_resetn,
  // request
  input wire logic                  i_valid,
  input wire iasbu_pkg::iasbu_req_t i_req,
  input wire logic                  o_ready,
  // answer
  input wire logic                  o_done,
  input wire iasbu_pkg::iasbu_res_t o_res,
  input wire logic                  o_ovf_fault,
  input wire logic                  o_zdiv_fault,
  // condition code
  input wire logic                  i_cc_wr,
  input wire logic [2:0]            i_cc_data,
  input wire logic [2:0]            o_cc
);
  logic        take;
  logic        dop;
  logic        tbit;
  logic        cout;
  logic [31:0] sum;
  logic [32:0] csum;
  // divide family op codes
  assign take = i_valid && o_ready;
  assign dop  = i_req.op inside {6'h06, 6'h07, 6'h0B, 6'h0C, 6'h0D, 6'h0E};
  assign tbit = i_req.src_a[i_req.src_b[4:0]];
  assign sum  = i_req.src_a + i_req.src_b;
  assign csum = {1'b0, i_req.src_a} + {1'b0, i_req.src_b} + {32'h0, o_cc[1]};
  assign cout = csum[32];
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // ready drops, no answer early
  sequence s_div_busy;
    !o_ready ##1 (!o_done) [*8];
  endsequence
  chk_div_latency: assert property (
    take && dop && (|i_req.src_b) |=> s_div_busy ##57 (o_done && o_ready))
    else $error("divide answer not at cycle 66");
  chk_zdiv_raise: assert property (
    take && dop && !(|i_req.src_b) |=> o_done && o_zdiv_fault)
    else $error("zero divisor not faulted");
  chk_zdiv_nowrite: assert property (
    o_zdiv_fault |-> !o_res.wr_lo && !o_res.wr_hi)
    else $error("zero divisor wrote a result");
  chk_single_done: assert property (
    take && !(dop && |i_req.src_b) |=> o_done)
    else $error("single cycle answer missing");
  chk_add_sum: assert property (
    take && i_req.op == 6'h01 |=> o_res.wr_lo && o_res.lo == $past(sum))
    else $error("ordinal add result wrong");
  chk_carry_out: assert property (
    take && i_req.op == 6'h08 |=> o_cc[1] == $past(cout))
    else $error("carry out wrong");
  chk_test_cc: assert property (
    take && i_req.op == 6'h2B |=> o_cc == ($past(tbit) ? 3'h2 : 3'h0))
    else $error("bit test code wrong");
  chk_cc_write: assert property (
    i_cc_wr && !take |=> o_cc == $past(i_cc_data))
    else $error("code write lost");
  chk_cc_hold: assert property (
    !take && !i_cc_wr |=> $stable(o_cc))
    else $error("code changed without cause");
  chk_ovf_done: assert property (
    o_ovf_fault |-> o_done)
    else $error("overflow fault without answer");
endmodule : iasbu_asserts

// ---- verif/iasbu_dec_model.sv ----
`timescale 1ns/1ps
module iasbu_dec_model (
  // clock
  input  wire logic             i_clk,
  // request to the unit
  input  wire logic             i_ready,
  output logic                  o_valid,
  output iasbu_pkg::iasbu_req_t o_req
);
  initial begin
    o_valid = 1'b0;
    o_req   = '0;
  end
  // present after gap cycles, hold until taken
  task automatic issue(input iasbu_pkg::iasbu_req_t r, input int gap);
    repeat (gap) @(posedge i_clk);
    o_valid <= 1'b1;
    o_req   <= r;
    @(posedge i_clk);
    while (!i_ready) @(posedge i_clk);
  endtask : issue
  // release, stale operands scrambled
  task automatic idle();
    o_valid <= 1'b0;
    o_req   <= ~o_req;
  endtask : idle
endmodule : iasbu_dec_model

// ---- verif/iasbu_tb_top.sv ----
`timescale 1ns/1ps
module iasbu_tb_top;
  logic                  clk;
  logic                  resetn;
  logic                  valid;
  logic                  ready;
  logic                  done;
  logic                  ovf;
  logic                  zdiv;
  logic                  cc_wr;
  logic [2:0]            cc_data;
  logic [2:0]            cc;
  iasbu_pkg::iasbu_req_t req;
  iasbu_pkg::iasbu_res_t res;
  iasbu_pkg::iasbu_res_t r_res;
  logic                  r_ovf;
  logic                  r_zdiv;
  int                    err_count = 0;
  int                    checks = 0;
  int                    cyc = 0;
  localparam logic [31:0] LA = 32'h0F0F33C5;
  localparam logic [31:0] LB = 32'h00FF5A3C;

  initial clk = 1'b0;
  always #4 clk = ~clk;

  iasbu_alu dut (.i_clk(clk), .i_resetn(resetn), .i_valid(valid),
    .i_req(req), .o_ready(ready), .o_done(done), .o_res(res),
    .o_ovf_fault(ovf), .o_zdiv_fault(zdiv), .i_cc_wr(cc_wr),
    .i_cc_data(cc_data), .o_cc(cc));
  iasbu_dec_model dec (.i_clk(clk), .i_ready(ready), .o_valid(valid),
    .o_req(req));

  task automatic final_report();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic cmp_w(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t word %h expected %h", $time, got, exp);
    end
  endtask : cmp_w

  task automatic cmp_b(input logic [2:0] got, input logic [2:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t code %b expected %b", $time, got, exp);
    end
  endtask : cmp_b

  // one request, wait for its answer
  task automatic run(input logic [5:0] op, input logic [31:0] a,
                     input logic [31:0] b, input logic [31:0] c);
    iasbu_pkg::iasbu_req_t r;
    int                    n;
    r = '{iasbu_pkg::iasbu_op_t'(op), a, b, c};
    n = 0;
    @(posedge clk);
    dec.issue(r, 0);
    dec.idle();
    @(negedge clk);
    while (done !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    cmp_b({2'b00, done}, 3'h1);
    r_res  = res;
    r_ovf  = ovf;
    r_zdiv = zdiv;
  endtask : run

  task automatic chk(input logic [5:0] op, input logic [31:0] a,
                     input logic [31:0] b, input logic [31:0] e);
    run(op, a, b, 32'h0);
    cmp_w(r_res.lo, e);
  endtask : chk

  task automatic set_cc(input logic [2:0] v);
    @(posedge clk);
    cc_wr   <= 1'b1;
    cc_data <= v;
    @(posedge clk);
    cc_wr   <= 1'b0;
    @(negedge clk);
    cmp_b(cc, v);
  endtask : set_cc

  task automatic t_basic();
    chk(6'h01, 32'hFFFFFFFF, 32'h2, 32'h1);
    chk(6'h00, 32'h7FFFFFFF, 32'h1, 32'h80000000);
    cmp_b({2'b00, r_ovf}, 3'h1);
    chk(6'h03, 32'h5, 32'h7, 32'hFFFFFFFE);
    chk(6'h05, 32'h10000, 32'h10001, 32'h10000);
    run(6'h3F, LA, LB, 32'h0);
    cmp_b({1'b0, r_res.wr_hi, r_res.wr_lo}, 3'h0);
    chk(6'h02, 32'h5, 32'h7, 32'hFFFFFFFE);
    chk(6'h04, 32'hFFFFFFFD, 32'h3, 32'hFFFFFFF7);
    chk(6'h06, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFD);
    chk(6'h07, 32'h64, 32'h7, 32'hE);
  endtask : t_basic

  task automatic t_carry();
    set_cc(3'h2);
    chk(6'h08, 32'hFFFFFFFF, 32'h0, 32'h0);
    cmp_b(cc, 3'h2);
    chk(6'h08, 32'h7FFFFFFF, 32'h0, 32'h80000000);
    cmp_b(cc, 3'h1);
    chk(6'h09, 32'h0, 32'h1, 32'hFFFFFFFE);
    cmp_b(cc, 3'h0);
  endtask : t_carry

  task automatic t_divide();
    chk(6'h0A, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h1);
    cmp_w(r_res.hi, 32'hFFFFFFFE);
    run(6'h0B, 32'h5, 32'h2, 32'h1);
    cmp_w(r_res.lo, 32'h1);
    cmp_w(r_res.hi, 32'h80000002);
    chk(6'h0C, 32'hFFFFFFF9, 32'h2, 32'hFFFFFFFF);
    chk(6'h0E, 32'hFFFFFFF9, 32'h2, 32'h1);
    chk(6'h0E, 32'h7, 32'hFFFFFFFE, 32'hFFFFFFFF);
    chk(6'h0D, 32'h7, 32'h3, 32'h1);
    run(6'h07, 32'h7, 32'h0, 32'h0);
    cmp_b({2'b00, r_zdiv}, 3'h1);
    cmp_b({1'b0, r_res.wr_hi, r_res.wr_lo}, 3'h0);
  endtask : t_divide

  task automatic t_shift();
    chk(6'h10, 32'h80000001, 32'h1, 32'h2);
    chk(6'h11, 32'h80000000, 32'h1F, 32'h1);
    chk(6'h12, 32'h40000000, 32'h1, 32'h80000000);
    cmp_b({2'b00, r_ovf}, 3'h1);
    chk(6'h12, 32'hFFFFFFFF, 32'h4, 32'hFFFFFFF0);
    cmp_b({2'b00, r_ovf}, 3'h0);
    chk(6'h13, 32'hFFFFFFF9, 32'h1, 32'hFFFFFFFC);
    chk(6'h14, 32'hFFFFFFF9, 32'h1, 32'hFFFFFFFD);
    chk(6'h14, 32'hFFFFFFF8, 32'h1, 32'hFFFFFFFC);
    chk(6'h15, 32'h80000001, 32'h1, 32'h3);
  endtask : t_shift

  task automatic t_logic();
    chk(6'h18, LA, LB, LA & LB);
    chk(6'h19, LA, LB, ~LA & LB);
    chk(6'h1A, LA, LB, LA & ~LB);
    chk(6'h1B, LA, LB, LA ^ LB);
    chk(6'h1C, LA, LB, LA | LB);
    chk(6'h1D, LA, LB, ~(LA | LB));
    chk(6'h1E, LA, LB, ~(LA ^ LB));
    chk(6'h1F, LA, LB, ~LA);
    chk(6'h20, LA, LB, ~LA | LB);
    chk(6'h21, LA, LB, LA | ~LB);
    chk(6'h22, LA, LB, ~(LA & LB));
  endtask : t_logic

  task automatic t_bits();
    chk(6'h28, 32'h0, 32'h1F, 32'h80000000);
    chk(6'h29, 32'hFFFFFFFF, 32'h0, 32'hFFFFFFFE);
    chk(6'h2A, 32'h5, 32'h2, 32'h1);
    run(6'h2B, 32'h8, 32'h3, 32'h0);
    cmp_b(cc, 3'h2);
    chk(6'h2C, 32'h0, 32'h4, 32'h10);
    run(6'h2B, 32'h8, 32'h2, 32'h0);
    cmp_b(cc, 3'h0);
    chk(6'h2C, 32'hFF, 32'h4, 32'hEF);
    chk(6'h2D, 32'h12345, 32'h0, 32'h10);
    cmp_b(cc, 3'h2);
    chk(6'h2E, 32'hFFFF7FFF, 32'h0, 32'hF);
    chk(6'h2D, 32'h0, 32'h0, 32'hFFFFFFFF);
    cmp_b(cc, 3'h0);
  endtask : t_bits

  // run length guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    resetn  = 1'b0;
    cc_wr   = 1'b0;
    cc_data = 3'h0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    t_basic();
    t_carry();
    t_divide();
    t_shift();
    t_logic();
    t_bits();
    final_report();
  end
endmodule : iasbu_tb_top

bind iasbu_alu iasbu_asserts u_chk (.i_clk(i_clk), .i_resetn(i_resetn),
  .i_valid(i_valid), .i_req(i_req), .o_ready(o_ready), .o_done(o_done),
  .o_res(o_res), .o_ovf_fault(o_ovf_fault), .o_zdiv_fault(o_zdiv_fault),
  .i_cc_wr(i_cc_wr), .i_cc_data(i_cc_data), .o_cc(o_cc));
